/* design/bias_ctrl_pkg.sv */
// Purpose: constants shared by the backlight/bias register bank and its host
// Assumes: one 40 MHz clock, asynchronous active-low reset
// Notes: the device answers a byte-wide register port with auto-increment
package bias_ctrl_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h03;
    localparam logic [7:0] ADDR_BRIGHT = 8'h04;
    localparam logic [7:0] ADDR_OVP = 8'h05;
    localparam logic [7:0] RST_CTRL = 8'h43;
    localparam logic [7:0] RST_BRIGHT = 8'hff;
    localparam logic [7:0] RST_OVP = 8'h00;
    localparam int OFS_LSB = 5;
    localparam int SEL_BIT = 4;
    localparam int EN_LSB = 2;
    localparam int DISP_BIT = 1;
    localparam int DISN_BIT = 0;
    localparam logic [7:0] OVP_MASK = 8'h03;
    localparam logic [7:0] MIN_BRIGHT = 8'h06;
    localparam logic [9:0] OFS_BASE_MV = 10'h064;
    localparam logic [9:0] OFS_STEP_MV = 10'h032;
    localparam logic [15:0] FULL_REF_MV = 16'h00c8;
    localparam logic [9:0] OVP_HI_DV = 10'h16d;
    localparam logic [9:0] OVP_MID_DV = 10'h132;
    localparam logic [9:0] OVP_LO_DV = 10'h0f8;
    localparam int SLOW_NS = 200_000;
    localparam int CLK_NS = 25;
    localparam int DUTY_WIN = SLOW_NS / CLK_NS;
    localparam int HOST_PWM_CYC = 400;
endpackage : bias_ctrl_pkg

/* design/bias_ctrl_if.sv */
// Purpose: byte register link between host and device
// Assumes: single clock
// Notes: wr/rd one-cycle strobes, rdData valid the cycle after rd
interface bias_ctrl_if (
    input wire logic clk
);
    logic start;
    logic [7:0] regAddr;
    logic wr;
    logic rd;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic dimPin;
    modport device (input clk, start, regAddr, wr, rd, wrData, dimPin, output rdData);
    modport host (input clk, rdData, output start, regAddr, wr, rd, wrData, dimPin);
endinterface : bias_ctrl_if

/* design/bias_ctrl_device.sv */
// Purpose: register bank steering bias enables, discharge and led reference
// Assumes: dimPin from another domain, synchronised here
// Notes: start loads the pointer; each wr/rd uses it then advances
module bias_ctrl_device
    import bias_ctrl_pkg::*;
(
    input wire logic rst_n,
    bias_ctrl_if.device link,
    input wire logic [9:0] positiveTargetMv,
    input wire logic [9:0] negativeTargetMv,
    input wire logic positiveEnablePin,
    input wire logic negativeEnablePin,
    output logic positiveOn,
    output logic negativeOn,
    output logic boostOn,
    output logic dischargePositive,
    output logic dischargeNegative,
    output logic [9:0] boostOffsetMv,
    output logic [10:0] boostTargetMv,
    output logic [15:0] feedbackRefQ8,
    output logic [9:0] overvoltageLimitDv,
    output logic brightnessSourceSelect
);
    logic clk;
    assign clk = link.clk;
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_q, ctrl_d, bright_q, bright_d, ovp_q, ovp_d, ptr_q, ptr_d;
    logic [7:0] rdData_q, rdData_d;
    logic [2:0] pinSync_q, pinSync_d;
    logic pinLvl_q, pinLvl_d;
    logic [15:0] winCnt_q, winCnt_d, hiCnt_q, hiCnt_d, duty_q, duty_d;
    logic [7:0] curData, ea;

    // a start in the same cycle as a strobe addresses that access directly
    always_comb begin
        ea = link.start ? link.regAddr : ptr_q;
        case (ea)
            ADDR_CTRL: curData = ctrl_q;
            ADDR_BRIGHT: curData = bright_q;
            ADDR_OVP: curData = ovp_q & OVP_MASK;
            default: curData = 8'h00;
        endcase
    end

    always_comb begin
        ctrl_d = ctrl_q;
        bright_d = bright_q;
        ovp_d = ovp_q;
        ptr_d = ptr_q;
        rdData_d = rdData_q;
        if (link.wr) begin
            case (ea)
                ADDR_CTRL: ctrl_d = link.wrData;
                ADDR_BRIGHT: bright_d = link.wrData;
                ADDR_OVP: ovp_d = link.wrData & OVP_MASK;
                default: ;
            endcase
            ptr_d = ea + 8'h01;
        end else if (link.rd) begin
            rdData_d = curData;
            ptr_d = ea + 8'h01;
        end else if (link.start) begin
            ptr_d = ea;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= RST_CTRL;
            bright_q <= RST_BRIGHT;
            ovp_q <= RST_OVP;
            ptr_q <= 8'h00;
            rdData_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            bright_q <= bright_d;
            ovp_q <= ovp_d;
            ptr_q <= ptr_d;
            rdData_q <= rdData_d;
        end
    end
    assign link.rdData = rdData_q;

    ////////////////////////////////////////////////////////////////////////////
    // pin duty measured over a fixed window, scaled to 1/256 mV
    always_comb begin
        pinSync_d = {pinSync_q[1:0], link.dimPin};
        pinLvl_d = (pinSync_q[2] == pinSync_q[1]) ? pinSync_q[2] : pinLvl_q;
        winCnt_d = winCnt_q + 16'h0001;
        hiCnt_d = hiCnt_q + {15'h0000, pinLvl_q};
        duty_d = duty_q;
        if (winCnt_q == 16'(DUTY_WIN - 1)) begin
            winCnt_d = 16'h0000;
            hiCnt_d = 16'h0000;
            duty_d = 16'((32'(hiCnt_q) * 32'(FULL_REF_MV) * 32'd256) / DUTY_WIN);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync_q <= 3'h0;
            pinLvl_q <= 1'b0;
            winCnt_q <= 16'h0000;
            hiCnt_q <= 16'h0000;
            duty_q <= 16'h0000;
        end else begin
            pinSync_q <= pinSync_d;
            pinLvl_q <= pinLvl_d;
            winCnt_q <= winCnt_d;
            hiCnt_q <= hiCnt_d;
            duty_q <= duty_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [9:0] negMag;
    logic [1:0] enField;
    logic [31:0] regRef;
    always_comb begin
        enField = ctrl_q[EN_LSB +: 2];
        positiveOn = enField[1] | positiveEnablePin;
        negativeOn = enField[0] | negativeEnablePin;
        boostOn = positiveOn | negativeOn;
        dischargePositive = ctrl_q[DISP_BIT] & ~positiveOn;
        dischargeNegative = ctrl_q[DISN_BIT] & ~negativeOn;
        boostOffsetMv = OFS_BASE_MV + OFS_STEP_MV * {7'h00, ctrl_q[OFS_LSB +: 3]};
        negMag = negativeTargetMv;
        boostTargetMv = {1'b0, (positiveTargetMv > negMag) ? positiveTargetMv : negMag}
            + {1'b0, boostOffsetMv};
        brightnessSourceSelect = ctrl_q[SEL_BIT];
        // reference in 1/256 mV: full scale 200 mV is 51200
        regRef = (32'(bright_q) + 32'd1) * 32'(FULL_REF_MV);
        if (brightnessSourceSelect) begin
            feedbackRefQ8 = pinLvl_q ? regRef[15:0] : 16'h0000;
        end else begin
            feedbackRefQ8 = duty_q;
        end
        case (ovp_q[1:0])
            2'b10: overvoltageLimitDv = OVP_MID_DV;
            2'b11: overvoltageLimitDv = OVP_LO_DV;
            default: overvoltageLimitDv = OVP_HI_DV;
        endcase
    end
endmodule : bias_ctrl_device

/* design/bias_ctrl_host.sv */
// Purpose: host end: forwards software byte writes/reads, drives dimming pin
// Assumes: software strobes as plain port, read data one cycle later
// Notes: pin mode emits a PWM; register mode holds the pin high; both only while backlightOn is set, pin low otherwise
module bias_ctrl_host
    import bias_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    bias_ctrl_if.host link,
    input wire logic [7:0] swAddr,
    input wire logic [7:0] swWrData,
    input wire logic swWr,
    input wire logic swRd,
    input wire logic [8:0] pwmDutySteps,
    input wire logic registerDimming,
    input wire logic backlightOn,
    output logic [7:0] swRdData
);
    logic [8:0] pwmCnt_q, pwmCnt_d;
    logic [7:0] fixData;
    always_comb begin
        pwmCnt_d = (pwmCnt_q == 9'(HOST_PWM_CYC - 1)) ? 9'h000 : pwmCnt_q + 9'h001;
        fixData = swWrData;
        if (swAddr == ADDR_OVP) fixData = swWrData & OVP_MASK;
        if (swAddr == ADDR_BRIGHT && swWrData < MIN_BRIGHT) fixData = MIN_BRIGHT;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pwmCnt_q <= 9'h000;
        else pwmCnt_q <= pwmCnt_d;
    end
    // each access reloads the device pointer with the address
    assign link.start = swWr | swRd;
    assign link.regAddr = swAddr;
    assign link.wr = swWr;
    assign link.rd = swRd;
    assign link.wrData = fixData;
    assign link.dimPin = backlightOn & (registerDimming | (pwmCnt_q < pwmDutySteps));
    assign swRdData = link.rdData;
endmodule : bias_ctrl_host

/* bench/bias_ctrl_props.sv */
// Purpose: link checks for the backlight/bias register bank
// Assumes: one clock, rst_n async low
// Notes: shadows follow the pointer and the three registers
module bias_ctrl_props
    import bias_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] regAddr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic dimPin
);
    logic [7:0] ea, ptr_q, ctrl_q, bright_q, ovp_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign ea = start ? regAddr : ptr_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= 8'h00;
            ctrl_q <= RST_CTRL;
            bright_q <= RST_BRIGHT;
            ovp_q <= RST_OVP;
        end else begin
            ptr_q <= (wr || rd) ? ea + 8'h01 : ea;
            if (wr && ea == ADDR_CTRL) ctrl_q <= wrData;
            if (wr && ea == ADDR_BRIGHT) bright_q <= wrData;
            if (wr && ea == ADDR_OVP) ovp_q <= wrData;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_strobe_excl: assert property (!(wr && rd))
        else $error("write and read strobes together");
    a_read_ctrl: assert property (rd && ea == ADDR_CTRL |=> rdData == $past(ctrl_q))
        else $error("control readback wrong");
    a_read_bright: assert property (rd && ea == ADDR_BRIGHT |=> rdData == $past(bright_q))
        else $error("brightness readback wrong");
    a_read_ovp: assert property (rd && ea == ADDR_OVP |=> rdData == ($past(ovp_q) & OVP_MASK))
        else $error("threshold readback wrong");
    a_ovp_clean: assert property (wr && ea == ADDR_OVP |-> (wrData & ~OVP_MASK) == 8'h00)
        else $error("reserved threshold bits written");
    a_bright_floor: assert property (wr && ea == ADDR_BRIGHT |-> wrData >= MIN_BRIGHT)
        else $error("brightness code below floor");
    c_pin_rise: cover property ($rose(dimPin));
endmodule : bias_ctrl_props

/* bench/bias_ctrl_tb.sv */
// Purpose: drive host software port, check device outputs and readback
// Assumes: one 40 MHz clock
// Notes: each access is a strobe cycle then an idle cycle
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module bias_ctrl_tb
    import bias_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst_n = 1'h0, swWr = 1'h0, swRd = 1'h0, rdQ = 1'h0;
    logic regDim = 1'h0, blOn = 1'h0, pE = 1'h0, nE = 1'h0, pOn, nOn, bOn, dP, dN, sel;
    logic [7:0] swAddr = 8'h00, swWrData = 8'h00, swRdData, b, rdExp, expQ[$];
    logic [8:0] duty = 9'h000;
    logic [9:0] posMv = 10'h000, negMv = 10'h000, ofsMv, ovpDv;
    logic [10:0] tgtMv;
    logic [15:0] refUv;
    logic [9:0] ovpTab[4] = '{OVP_HI_DV, OVP_HI_DV, OVP_MID_DV, OVP_LO_DV};
    int mismatches = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    bias_ctrl_if bias_ctrl_if_inst (.clk(clk));
    bias_ctrl_host bias_ctrl_host_inst (.clk(clk), .rst_n(rst_n), .link(bias_ctrl_if_inst.host),
        .swAddr(swAddr), .swWrData(swWrData), .swWr(swWr), .swRd(swRd), .pwmDutySteps(duty),
        .registerDimming(regDim), .backlightOn(blOn), .swRdData(swRdData));
    bias_ctrl_device bias_ctrl_device_inst (.rst_n(rst_n), .link(bias_ctrl_if_inst.device),
        .positiveTargetMv(posMv), .negativeTargetMv(negMv), .positiveEnablePin(pE),
        .negativeEnablePin(nE), .positiveOn(pOn), .negativeOn(nOn), .boostOn(bOn),
        .dischargePositive(dP), .dischargeNegative(dN), .boostOffsetMv(ofsMv),
        .boostTargetMv(tgtMv), .feedbackRefQ8(refUv), .overvoltageLimitDv(ovpDv),
        .brightnessSourceSelect(sel));
    bias_ctrl_props bias_ctrl_props_inst (.clk(clk), .rst_n(rst_n),
        .start(bias_ctrl_if_inst.start), .regAddr(bias_ctrl_if_inst.regAddr),
        .wr(bias_ctrl_if_inst.wr), .rd(bias_ctrl_if_inst.rd), .wrData(bias_ctrl_if_inst.wrData),
        .rdData(bias_ctrl_if_inst.rdData), .dimPin(bias_ctrl_if_inst.dimPin));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        swAddr <= a;
        swWrData <= d;
        swWr <= w;
        swRd <= !w;
        if (!w) expQ.push_back(d);
        @(posedge clk);
        swWr <= 1'h0;
        swRd <= 1'h0;
        @(posedge clk);
    endtask : acc
    always @(negedge clk) begin
        if (rdQ) begin
            rdExp = expQ.pop_front();
            `CHK(swRdData, rdExp)
        end
        rdQ = swRd;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    initial begin
        #1ms;
        mismatches++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h5fd0));
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        acc(1'h0, ADDR_CTRL, RST_CTRL);
        acc(1'h0, ADDR_BRIGHT, RST_BRIGHT);
        acc(1'h0, ADDR_OVP, RST_OVP);
        @(negedge clk);
        `CHK(ofsMv, 10'h0c8)
        $display("test reset done");
        for (int i = 0; i < 36; i++) begin
            b = {i[2:0], i == 35, i[4:3], 2'($urandom)};
            pE <= 1'($urandom);
            nE <= 1'($urandom);
            posMv <= 10'($urandom);
            negMv <= 10'($urandom);
            duty <= 9'($urandom);
            if (i > 31) acc(1'h1, ADDR_OVP, {6'h00, i[1:0]});
            acc(1'h1, ADDR_CTRL, b);
            acc(1'h0, i > 31 ? ADDR_OVP : ADDR_CTRL, i > 31 ? {6'h00, i[1:0]} : b);
            @(negedge clk);
            if (i > 31) `CHK(ovpDv, ovpTab[i[1:0]])
            `CHK(ofsMv, OFS_BASE_MV + OFS_STEP_MV * b[7:5])
            `CHK(tgtMv, 11'(posMv > negMv ? posMv : negMv) + 11'(ofsMv))
            `CHK(sel, b[SEL_BIT])
            `CHK(pOn, b[3] | pE)
            `CHK(nOn, b[2] | nE)
            `CHK(bOn, b[3] | pE | b[2] | nE)
            `CHK(dP, b[1] & !(b[3] | pE))
            `CHK(dN, b[0] & !(b[2] | nE))
        end
        $display("test ctrl done");
        regDim <= 1'h1;
        blOn <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            b = i == 0 ? MIN_BRIGHT : i == 1 ? 8'hff : 8'($urandom_range(255, 6));
            acc(1'h1, ADDR_BRIGHT, b);
            acc(1'h0, ADDR_BRIGHT, b);
            @(negedge clk);
            `CHK(refUv, (16'(b) + 16'h0001) * FULL_REF_MV)
        end
        blOn <= 1'h0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        `CHK(refUv, 16'h0000)
        @(posedge clk);
        blOn <= 1'h1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        `CHK(refUv, (16'(b) + 16'h0001) * FULL_REF_MV)
        @(posedge clk);
        acc(1'h0, ADDR_BRIGHT, b);
        acc(1'h1, ADDR_CTRL, RST_CTRL);
        regDim <= 1'h0;
        duty <= 9'($urandom_range(399, 0));
        repeat (3 * DUTY_WIN) @(posedge clk);
        @(negedge clk);
        `CHK(refUv, 16'((32'(duty) * 32'(FULL_REF_MV) * 32'd256) / HOST_PWM_CYC))
        repeat (3) @(posedge clk);
        $display("test dimming done");
        test_done();
    end
endmodule : bias_ctrl_tb
